// ### include/sac_pkg.sv
// constants and carrier types for the converter sequencer control
// assumes one 125 MHz system clock standing in for the instruction clock
package sac_pkg;
	localparam int unsigned SAC_RES_W = 10;
	localparam int unsigned SAC_PINS = 16;
	localparam int unsigned SAC_BUF_DEPTH = 16;
	localparam logic [3:0] SAC_CONV_TADS = 4'h000c; // twelve periods per conversion
	localparam real SAC_TAD_MIN_NS = 83.33;
	localparam real SAC_CLK_NS = 8.0;
	// least tad in system cycles, rounded up
	localparam int unsigned SAC_TAD_MIN_CYC = int'($ceil(SAC_TAD_MIN_NS / SAC_CLK_NS));
	localparam logic [2:0] SAC_TRIG_AUTO = 3'h7; // internal counter ends sampling
	localparam logic [2:0] SAC_TRIG_MANUAL = 3'h0;
	localparam logic [SAC_RES_W-1:0] SAC_CODE_MAX = 10'h03ff;
	localparam logic [SAC_RES_W-1:0] SAC_CODE_MIN = 10'h0000;
	localparam logic [15:0] SAC_PCFG_RST = 16'h0000;

	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_CONVERT = 2'b10
	} sac_state_e;

	// software control bits
	typedef struct packed {
		logic converter_power_on;
		logic manual_sample_bit;
		logic auto_sample_enable;
		logic [2:0] trigger_source_select;
		logic simultaneous_sample_select;
		logic [1:0] hold_channel_count;
		logic [3:0] conversions_per_interrupt;
		logic [5:0] conversion_clock_select;
		logic [4:0] auto_sample_duration;
	} sac_ctrl_s;

	// analog front end: one code per hold channel from comparator array
	typedef struct packed {
		logic [3:0][SAC_RES_W-1:0] code;
	} sac_ana_s;
endpackage : sac_pkg

// ### rtl/sac_tad_div.sv
// conversion clock divider: one-cycle tad enable pulse
// assumes select value is stable while the converter runs
`timescale 1ns/1ns
module sac_tad_div
(
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic run, // divider runs while high
	input wire logic [5:0] sel, // clock select field
	output logic tad_en // one pulse per tad
);
	import sac_pkg::*;
	logic [6:0] cnt_r;
	logic [6:0] limit;

	// period is (sel+1) system cycles; zero gives the fastest tad
	assign limit = 7'(sel) + 7'h0000;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_r <= 7'h0000;
			tad_en <= 1'b0;
		end
		else if (!run)
		begin
			cnt_r <= 7'h0000;
			tad_en <= 1'b0;
		end
		else
		begin
			tad_en <= (cnt_r >= limit); // RULE_10
			cnt_r <= (cnt_r >= limit) ? 7'h0000 : cnt_r + 7'h0001;
		end
	end

	tad_period_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_10
		run && $past(run) && tad_en |=> !tad_en || (sel == 6'h00))
		else $error("tad pulses too close");
endmodule : sac_tad_div

// ### rtl/sac_seq.sv
// sequencer for a ten-bit successive approximation converter
// assumes analog codes and pin config come from the analog macro; control bits from software
`timescale 1ns/1ns

// What this block does
// RULE_01 - manual sample bit starts acquisition
// RULE_02 - manual start ignores auto sample duration
// RULE_03 - clearing manual bit ends sampling, converts
// RULE_04 - sequence end sets done and flag; here the flag is set by the RULE_09 conversion count, not by sequence end
// RULE_05 - trigger 111: counter ends sampling
// RULE_06 - auto sample restarts sampling by itself
// RULE_07 - simultaneous or sequential hold channel sampling
// RULE_08 - channel count field picks channels
// RULE_09 - conversions per interrupt before flag
// RULE_10 - clock select derives conversion clock
// RULE_11 - sample time in conversion clock periods
// RULE_12 - twelve periods per conversion
// RULE_13 - convert one channel while other acquires
// RULE_14 - sequential sampling shares aggregate rate
// RULE_15 - software routes pins to channels; no routing in this block, ana gives one code per hold channel
// RULE_16 - code saturates at ten-bit limits
// RULE_17 - pin config bit set makes pin digital
// RULE_18 - results fill buffer, pointer restarts
module sac_seq
(
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	input wire sac_pkg::sac_ctrl_s ctrl, // software control bits
	input wire logic flag_clr, // software clears interrupt flag
	input wire logic done_clr, // software clears done
	input wire logic [15:0] pin_cfg, // pin config, 1 = digital
	input wire sac_pkg::sac_ana_s ana, // comparator codes per hold channel
	input wire logic [3:0] buf_idx, // result buffer read index
	output logic [9:0] buf_data, // result buffer read data
	output logic [3:0] hold_track, // hold channel tracking
	output logic [15:0] pin_analog, // pin in analog mode
	output logic conv_busy, // conversion in progress
	output logic done, // sequence complete
	output logic conversion_irq_flag // interrupt flag
);
	import sac_pkg::*;

	sac_state_e st_r;
	sac_state_e st_nxt;
	logic tad_en;
	logic [4:0] manual_sample_bit_cnt_r;
	logic [3:0] conv_cnt_r;
	logic [1:0] ch_r;
	logic [3:0] int_cnt_r;
	logic [3:0] wptr_r;
	logic manual_sample_bit_d_r;
	logic [9:0] rbuf [SAC_BUF_DEPTH];
	logic [2:0] nch;
	logic [4:0] manual_sample_bit_len;
	logic auto_trig;
	logic manual_sample_bit_fall;
	logic manual_sample_bit_end;
	logic conv_last;
	logic chan_last;
	logic seq_end;
	logic irq_due;
	logic [9:0] code_sat;

	// clamp a raw code to the ten-bit span
	function automatic logic [9:0] sat10(input logic [9:0] c);
		sat10 = (c > SAC_CODE_MAX) ? SAC_CODE_MAX : c;
	endfunction : sat10

	sac_tad_div u_div
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.run(ctrl.converter_power_on),
		.sel(ctrl.conversion_clock_select),
		.tad_en(tad_en)
	);

	// decode of mode and counts
	assign nch = (ctrl.hold_channel_count == 2'b00) ? 3'h1 : // RULE_08
		(ctrl.hold_channel_count == 2'b01) ? 3'h2 : 3'h4;
	assign auto_trig = (ctrl.trigger_source_select == SAC_TRIG_AUTO); // RULE_05
	// zero duration still needs one tad, a zero-length acquisition is useless
	assign manual_sample_bit_len = (ctrl.auto_sample_duration == 5'h00) ? 5'h01 : ctrl.auto_sample_duration;
	assign manual_sample_bit_fall = manual_sample_bit_d_r && !ctrl.manual_sample_bit;
	// manual trigger ignores the duration field entirely
	assign manual_sample_bit_end = auto_trig ? (tad_en && (manual_sample_bit_cnt_r + 5'h01 >= manual_sample_bit_len)) // RULE_11
		: manual_sample_bit_fall; // RULE_02 RULE_03
	assign conv_last = tad_en && (conv_cnt_r == SAC_CONV_TADS - 4'h1); // RULE_12
	assign chan_last = (3'(ch_r) + 3'h1 >= nch);
	assign seq_end = conv_last && chan_last;
	assign irq_due = (int_cnt_r == ctrl.conversions_per_interrupt); // RULE_09
	assign code_sat = sat10(ana.code[ch_r]); // RULE_16

	// next state
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			SAC_IDLE:
				if (ctrl.converter_power_on && (ctrl.manual_sample_bit || ctrl.auto_sample_enable))
					st_nxt = SAC_SAMPLE; // RULE_01 RULE_06
			SAC_SAMPLE:
				if (!ctrl.converter_power_on)
					st_nxt = SAC_IDLE;
				else if (manual_sample_bit_end)
					st_nxt = SAC_CONVERT;
			SAC_CONVERT:
				if (!ctrl.converter_power_on)
					st_nxt = SAC_IDLE;
				else if (seq_end)
					st_nxt = ctrl.auto_sample_enable ? SAC_SAMPLE : SAC_IDLE; // RULE_06
			default:
				st_nxt = SAC_IDLE;
		endcase
	end

	// state and counters
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= SAC_IDLE;
			manual_sample_bit_d_r <= 1'b0;
			manual_sample_bit_cnt_r <= 5'h00;
			conv_cnt_r <= 4'h0;
			ch_r <= 2'h0;
		end
		else
		begin
			st_r <= st_nxt;
			manual_sample_bit_d_r <= ctrl.manual_sample_bit;
			if (st_r != SAC_SAMPLE)
				manual_sample_bit_cnt_r <= 5'h00;
			else if (tad_en)
				manual_sample_bit_cnt_r <= manual_sample_bit_cnt_r + 5'h01;
			if (st_r != SAC_CONVERT || conv_last)
				conv_cnt_r <= 4'h0;
			else if (tad_en)
				conv_cnt_r <= conv_cnt_r + 4'h1;
			if (st_r != SAC_CONVERT || seq_end)
				ch_r <= 2'h0;
			else if (conv_last)
				ch_r <= ch_r + 2'h1; // RULE_07
		end
	end

	// hold channel tracking: unconverted channels acquire again after the first convert cycle, except in simultaneous mode where all hold during convert
	// sequential mode lets a later channel acquire while an earlier converts
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			hold_track <= 4'h0;
		else
			for (int i = 0; i < 4; i++)
			begin
				if (3'(i) >= nch)
					hold_track[i] <= 1'b0;
				else if (st_nxt == SAC_SAMPLE)
					hold_track[i] <= 1'b1; // RULE_07
				else if (st_nxt == SAC_CONVERT)
					hold_track[i] <= ctrl.simultaneous_sample_select ? 1'b0 // RULE_07
						: (2'(i) > ch_r) && !(st_r == SAC_SAMPLE); // RULE_13 RULE_14
				else
					hold_track[i] <= 1'b0;
			end
	end

	// write pointer and conversion count restart together at each flag
	// keeping them in step means word zero always holds the first result of a group
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wptr_r <= 4'h0;
			int_cnt_r <= 4'h0;
		end
		else if (st_r == SAC_CONVERT && conv_last)
		begin
			wptr_r <= irq_due ? 4'h0 : wptr_r + 4'h1; // RULE_18
			int_cnt_r <= irq_due ? 4'h0 : int_cnt_r + 4'h1; // RULE_09
		end
	end

	// done: set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			done <= 1'b0;
		else if (st_r == SAC_CONVERT && seq_end)
			done <= 1'b1; // RULE_04
		else if (done_clr || (st_nxt == SAC_SAMPLE && st_r != SAC_SAMPLE))
			done <= 1'b0;
	end

	// flag: a late software clear must not lose a fresh group
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			conversion_irq_flag <= 1'b0;
		else if (st_r == SAC_CONVERT && conv_last && irq_due)
			conversion_irq_flag <= 1'b1; // RULE_04 RULE_09
		else if (flag_clr)
			conversion_irq_flag <= 1'b0;
	end

	// buffer storage without reset
	always_ff @(posedge clk_sys)
	begin
		if (st_r == SAC_CONVERT && conv_last)
			rbuf[wptr_r] <= code_sat; // RULE_18
	end

	// outputs
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			buf_data <= 10'h000;
			pin_analog <= ~SAC_PCFG_RST; // RULE_17
			conv_busy <= 1'b0;
		end
		else
		begin
			buf_data <= rbuf[buf_idx];
			pin_analog <= ~pin_cfg; // RULE_17
			conv_busy <= (st_nxt == SAC_CONVERT);
		end
	end

	// conversion length and channel walk
	conv_len_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_12
		(st_r == SAC_CONVERT) && conv_last |-> conv_cnt_r == SAC_CONV_TADS - 4'h1)
		else $error("conversion not twelve tads");

	conv_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_12
		conv_cnt_r < SAC_CONV_TADS)
		else $error("conversion counter overran");

	chan_count_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_08
		st_r == SAC_CONVERT |-> 3'(ch_r) < nch)
		else $error("channel beyond count");

	chan_step_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_07
		st_r == SAC_CONVERT && conv_last && !seq_end && ctrl.converter_power_on
		|=> ch_r == $past(ch_r) + 2'h1)
		else $error("channel did not advance");

	// sampling start and end
	manual_start_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_01
		st_r == SAC_IDLE && ctrl.converter_power_on && ctrl.manual_sample_bit
		|=> st_r == SAC_SAMPLE)
		else $error("manual sample did not start");

	manual_end_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_03
		st_r == SAC_SAMPLE && !auto_trig && manual_sample_bit_fall && ctrl.converter_power_on
		|=> st_r == SAC_CONVERT)
		else $error("clearing sample bit did not convert");

	ignore_dur_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_02
		st_r == SAC_SAMPLE && !auto_trig && !manual_sample_bit_fall |=> st_r != SAC_CONVERT)
		else $error("manual sampling ended by counter");

	auto_end_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_05 RULE_11
		st_r == SAC_SAMPLE && auto_trig && tad_en && manual_sample_bit_cnt_r + 5'h01 >= manual_sample_bit_len
		&& ctrl.converter_power_on |=> st_r == SAC_CONVERT)
		else $error("auto trigger did not convert");

	manual_sample_bit_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_11
		st_r == SAC_IDLE |=> manual_sample_bit_cnt_r == 5'h00)
		else $error("sample counter kept stale count");

	auto_restart_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_06
		st_r == SAC_CONVERT && seq_end && ctrl.auto_sample_enable && ctrl.converter_power_on
		|=> st_r == SAC_SAMPLE)
		else $error("auto sample did not restart");

	power_off_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_01
		!ctrl.converter_power_on |=> st_r == SAC_IDLE)
		else $error("power off did not idle");

	tad_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_10
		!ctrl.converter_power_on |=> !tad_en)
		else $error("tad pulse while powered off");

	busy_state_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_03
		conv_busy == (st_r == SAC_CONVERT))
		else $error("busy out of step with state");

	// hold channel tracking
	idle_track_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_01
		st_r == SAC_IDLE |-> hold_track == 4'h0)
		else $error("tracking while idle");

	sample_track_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_01
		st_r == SAC_SAMPLE |-> hold_track[0])
		else $error("first channel not tracking");

	simul_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_07
		st_r == SAC_CONVERT && $past(ctrl.simultaneous_sample_select) |-> hold_track == 4'h0)
		else $error("simultaneous channel tracking in convert");

	seq_track_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_13
		st_r == SAC_CONVERT && $past(st_r) == SAC_CONVERT
		&& !$past(ctrl.simultaneous_sample_select) && $past(ch_r) == 2'h0
		&& $past(nch) >= 3'h2 |-> hold_track[1])
		else $error("second channel idle during first convert");

	unused_chan_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_08
		hold_track[3] |-> $past(nch) == 3'h4)
		else $error("unused channel tracking");

	// results, status and flag
	saturate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_16
		code_sat <= SAC_CODE_MAX)
		else $error("code out of range");

	wptr_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_18
		st_r == SAC_CONVERT && conv_last && irq_due |=> wptr_r == 4'h0)
		else $error("pointer did not restart");

	wptr_step_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_18
		st_r == SAC_CONVERT && conv_last && !irq_due |=> wptr_r == $past(wptr_r) + 4'h1)
		else $error("pointer did not advance");

	done_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_04
		st_r == SAC_CONVERT && seq_end |=> done)
		else $error("done not set at sequence end");

	done_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_04
		done && !done_clr && !(st_nxt == SAC_SAMPLE && st_r != SAC_SAMPLE) |=> done)
		else $error("done dropped by itself");

	irq_count_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_09
		st_r == SAC_CONVERT && conv_last && !irq_due && !conversion_irq_flag && !flag_clr
		|=> !conversion_irq_flag)
		else $error("flag raised early");

	flag_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_09
		conversion_irq_flag && !flag_clr |=> conversion_irq_flag)
		else $error("flag dropped by itself");

	pin_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE_17
		##1 pin_analog == ~$past(pin_cfg))
		else $error("pin mode mismatch");
endmodule : sac_seq

// ### verif/sac_ana_model.sv
// analog front end stand-in: one held code per hold channel
// assumes hold_track from the sequencer and one shared input level vin
`timescale 1ns/1ns
module sac_ana_model
(
	input wire logic clk_sys, // system clock
	input wire logic [3:0] hold_track, // channel tracking
	input wire logic [10:0] vin, // input level in lsb steps
	output sac_pkg::sac_ana_s ana // code per hold channel
);
	import sac_pkg::*;
	// start from ground so an untouched channel never reads unknown
	logic [10:0] lvl_r [4] = '{default: 11'h000};
	// held level freezes once tracking stops, like a hold capacitor
	// one pin routed to every channel, offset per channel to tell them apart
	always_ff @(posedge clk_sys)
	begin
		for (int i = 0; i < 4; i++)
			if (hold_track[i])
				lvl_r[i] <= vin + 11'(i);
	end
	// comparator result clips at the ten-bit limits
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			ana.code[i] = (lvl_r[i] > 11'h3ff) ? SAC_CODE_MAX : lvl_r[i][9:0];
	end
endmodule : sac_ana_model

// ### verif/tb_sac_seq.sv
// self-checking bench for the converter sequencer
// assumes sac_seq and the analog model; inputs change on falling edges
`timescale 1ns/1ns
module tb_sac_seq;
	import sac_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	sac_ctrl_s ctrl = '0;
	logic flag_clr = 1'b0;
	logic done_clr = 1'b0;
	logic [15:0] pin_cfg = 16'h0000;
	logic [3:0] buf_idx = 4'h0;
	logic [10:0] vin = 11'h000;
	sac_ana_s ana;
	logic [9:0] buf_data;
	logic [3:0] hold_track;
	logic [15:0] pin_analog;
	logic conv_busy;
	logic done;
	logic conversion_irq_flag;
	int n_errors = 0;
	int total_checks = 0;
	int cnt;
	logic seen;
	always #4 clk_sys = ~clk_sys;
	sac_seq u_sac_seq (.clk_sys(clk_sys), .nrst(nrst), .ctrl(ctrl), .flag_clr(flag_clr),
		.done_clr(done_clr), .pin_cfg(pin_cfg), .ana(ana), .buf_idx(buf_idx),
		.buf_data(buf_data), .hold_track(hold_track), .pin_analog(pin_analog),
		.conv_busy(conv_busy), .done(done), .conversion_irq_flag(conversion_irq_flag));
	sac_ana_model u_sac_ana_model (.clk_sys(clk_sys), .hold_track(hold_track), .vin(vin),
		.ana(ana));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// registered read port: data lands one edge after the index
	task automatic read_buf(input logic [3:0] idx, input logic [9:0] exp);
		buf_idx = idx;
		cyc(1);
		chk("buf_data", {6'h00, exp}, {6'h00, buf_data});
	endtask : read_buf
	// bounded wait so a stuck sequencer cannot hang the run
	task automatic wait_flag(input int lim);
		cnt = 0;
		while (conversion_irq_flag !== 1'b1 && cnt < lim)
		begin
			cyc(1);
			cnt++;
		end
		chk("conversion_irq_flag", 16'h0001, {15'h0000, conversion_irq_flag});
	endtask : wait_flag
	task automatic clr();
		flag_clr = 1'b1;
		done_clr = 1'b1;
		cyc(1);
		flag_clr = 1'b0;
		done_clr = 1'b0;
	endtask : clr
	task automatic final_report();
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// main sequence
	initial
	begin
		cyc(8);
		chk("pin_analog", 16'hffff, pin_analog);
		nrst = 1'b1;
		pin_cfg = 16'hfffb;
		cyc(2);
		chk("pin_analog", 16'h0004, pin_analog);
		// manual sampling far past the programmed duration
		vin = 11'h123;
		ctrl.converter_power_on = 1'b1;
		ctrl.conversion_clock_select = 6'h01;
		ctrl.auto_sample_duration = 5'h02;
		ctrl.manual_sample_bit = 1'b1;
		cyc(40);
		chk("hold_track", 16'h0001, {12'h000, hold_track});
		chk("conv_busy", 16'h0000, {15'h0000, conv_busy});
		ctrl.manual_sample_bit = 1'b0;
		cnt = 0;
		repeat (80)
		begin
			cyc(1);
			if (conv_busy === 1'b1)
				cnt++;
		end
		chk("busy span", 16'h0001, {15'h0000, cnt >= 23 && cnt <= 26});
		chk("done", 16'h0001, {15'h0000, done});
		chk("conversion_irq_flag", 16'h0001, {15'h0000, conversion_irq_flag});
		read_buf(4'h0, 10'h123);
		clr();
		// auto trigger, two channels, flag after two results
		vin = 11'h3fe;
		ctrl.trigger_source_select = SAC_TRIG_AUTO;
		ctrl.hold_channel_count = 2'b01;
		ctrl.conversions_per_interrupt = 4'h1;
		ctrl.auto_sample_enable = 1'b1;
		wait_flag(400);
		read_buf(4'h0, 10'h3fe);
		read_buf(4'h1, 10'h3ff);
		// over-range input clips; sampling restarts with no manual bit
		vin = 11'h5ff;
		clr();
		wait_flag(400);
		chk("done", 16'h0001, {15'h0000, done});
		clr();
		wait_flag(400);
		read_buf(4'h0, 10'h3ff);
		// simultaneous sampling on four channels
		clr();
		vin = 11'h100;
		ctrl.simultaneous_sample_select = 1'b1;
		ctrl.hold_channel_count = 2'b10;
		ctrl.conversions_per_interrupt = 4'h3;
		seen = 1'b0;
		repeat (200)
		begin
			cyc(1);
			if (hold_track === 4'hf)
				seen = 1'b1;
		end
		chk("all tracking", 16'h0001, {15'h0000, seen});
		clr();
		wait_flag(800);
		for (int i = 0; i < 4; i++)
			read_buf(4'(i), 10'h100 + 10'(i));
		// power off drops back to idle at once
		ctrl.converter_power_on = 1'b0;
		cyc(2);
		chk("conv_busy", 16'h0000, {15'h0000, conv_busy});
		chk("hold_track", 16'h0000, {12'h000, hold_track});
		final_report();
	end
	// watchdog, well beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		n_errors++;
		final_report();
	end
endmodule : tb_sac_seq
